/* rtl/tcp_top.sv */
// Three-channel pulse-width unit with parameter blocks and status bits.
//
// Function
// - variant one codes give 11.44/45.78/366.2 Hz
// - variant two codes give 15.26/61.04/488.3 Hz
// - high time is period times duty over 100
// - channels drive outputs a, b, c respectively
// - free-running channel runs while start stays high
// - count enable: 0 free, 1 counted, ch1/ch3
// - counted channels stop after exact preset pulses
// - preset is 32-bit high/low word, 1..100000000
// - ch1/ch3 running count published each scan as word pair
// - start rise checks: 0 ok, 1 freq, 2 duty
// - code 3 bad enable, code 4 bad preset
// - code 5 counting requested on channel two
// - count and error words ignore writes
// - each channel block is eight consecutive words
// - running bit set while generating pulses
// - done bit sets on stop, clears on start
// - overflow bit sets past preset, clears on start
// - duty change takes effect from next scan
//
// The address-and-strobe port was decided locally.
`default_nettype none
module tcp_top
  import tcp_pkg::*;
#(
  parameter bit VARIANT = 1'b0,
  parameter logic [AW-1:0] PARAM_BASE = 5'h00,
  parameter int unsigned PERIOD_A0 = period_cycles(FREQ_A0_MHZ),
  parameter int unsigned PERIOD_A1 = period_cycles(FREQ_A1_MHZ),
  parameter int unsigned PERIOD_A2 = period_cycles(FREQ_A2_MHZ),
  parameter int unsigned PERIOD_B0 = period_cycles(FREQ_B0_MHZ),
  parameter int unsigned PERIOD_B1 = period_cycles(FREQ_B1_MHZ),
  parameter int unsigned PERIOD_B2 = period_cycles(FREQ_B2_MHZ),
  parameter int unsigned SCAN_CYCLES = CLK_HZ / US_PER_S * SCAN_US
)
(
  input wire logic mclk, // System clock, 40 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [AW-1:0] reg_addr, // Register word address.
  input wire logic [DW-1:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [DW-1:0] reg_rdata, // Read data, cycle after strobe.
  input wire logic [NUM_CH-1:0] start_in, // Start inputs, one per channel.
  output logic pulse_out_a, // Channel one output.
  output logic pulse_out_b, // Channel two output.
  output logic pulse_out_c, // Channel three output.
  output logic [NUM_CH-1:0] pulse_oe, // High while a channel owns its output.
  output logic [NUM_CH-1:0] running_flag, // Generating pulses.
  output logic [NUM_CH-1:0] done_flag, // Run has ended.
  output logic [NUM_CH-1:0] overrun_flag // More pulses than the preset.
);
  // Period and scan constants are cut to the counter width on purpose.
  localparam logic [CW-1:0] SCAN_LAST = CW'(SCAN_CYCLES - 1);
  localparam logic [CW-1:0] P_A0 = CW'(PERIOD_A0);
  localparam logic [CW-1:0] P_A1 = CW'(PERIOD_A1);
  localparam logic [CW-1:0] P_A2 = CW'(PERIOD_A2);
  localparam logic [CW-1:0] P_B0 = CW'(PERIOD_B0);
  localparam logic [CW-1:0] P_B1 = CW'(PERIOD_B1);
  localparam logic [CW-1:0] P_B2 = CW'(PERIOD_B2);

  // Splits an address into a hit flag, channel and word within the block.
  // A base too close to the top of the address space simply loses the upper
  // channels, whose addresses would wrap.
  function automatic logic [5:0] decode(input logic [AW-1:0] a);
    logic [AW-1:0] rel;
    logic [1:0] ch;
    logic hit;
    rel = a - PARAM_BASE;
    ch = rel[4:3];
    hit = (a >= PARAM_BASE) && (ch < 2'(NUM_CH));
    return {hit, ch, rel[2:0]};
  endfunction : decode

  // Codes above two fall back to code zero; the start check refuses them, so
  // this only matters when software rewrites the code during a run.
  // period table for variant one or two
  function automatic logic [CW-1:0] period_of(input logic [DW-1:0] code);
    logic [CW-1:0] p;
    case (code)
      16'h0001: p = VARIANT ? P_B1 : P_A1;
      16'h0002: p = VARIANT ? P_B2 : P_A2;
      default: p = VARIANT ? P_B0 : P_A0;
    endcase
    return p;
  endfunction : period_of

  logic [DW-1:0] freq_reg [NUM_CH];
  logic [DW-1:0] duty_reg [NUM_CH];
  logic [DW-1:0] cnten_reg [NUM_CH];
  logic [DW-1:0] prehi_reg [NUM_CH];
  logic [DW-1:0] prelo_reg [NUM_CH];
  logic [CW-1:0] cntpub_reg [NUM_CH];
  logic [DW-1:0] err_reg [NUM_CH];
  logic [CW-1:0] scan_cnt_reg;
  logic scan_tick;
  // Decoded write and read addresses: hit flag, channel and word.
  logic [5:0] wdec;
  logic [5:0] rdec;
  logic [NUM_CH-1:0] pwm;

  assign wdec = decode(reg_addr);
  assign rdec = decode(reg_addr);
  assign scan_tick = (scan_cnt_reg == SCAN_LAST);

  // Scan pacing enable.
  // The scan counter runs freely from reset, so duty pickup and the published
  // count may lag a write or a pulse by up to one scan.
  always_ff @(posedge mclk) begin
    if (sys_rst || scan_tick) begin
      scan_cnt_reg <= '0;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 32'h00000001;
    end
  end

  // Outputs are registered in the channels; only the mapping happens here.
  // output mapping
  assign pulse_out_a = pwm[0];
  assign pulse_out_b = pwm[1];
  assign pulse_out_c = pwm[2];
  assign pulse_oe = running_flag;

  // Each channel keeps its own start edge, check, counters and status bits;
  // only the write strobe, write data, decoded address and the scan enable are shared.
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      localparam bit CAN_COUNT = (g != 1);
      logic start_d_reg;
      logic start_rise;
      logic [CW-1:0] preset;
      logic [CW-1:0] pcnt_reg;
      logic [6:0] duty_scan_reg;
      logic counted_reg;
      logic pend;
      logic [DW-1:0] chk;
      logic reach;
      logic stop_now;
      logic wr_hit;
      logic [6:0] duty_now;
      logic [CW-1:0] period_sel;

      assign preset = {prehi_reg[g], prelo_reg[g]};
      assign start_rise = start_in[g] && !start_d_reg;

      // The checks run on the live words every cycle, and the result is only
      // captured on the start edge, so a later write cannot refuse a run
      // that is already going.
      // frequency, duty, enable and preset checks
      always_comb begin
        chk = ERR_NONE;
        if (freq_reg[g] > FREQ_MAX) begin
          chk = ERR_FREQ;
        end else if (duty_reg[g] < DUTY_MIN || duty_reg[g] > DUTY_MAX) begin
          chk = ERR_DUTY;
        end else if (!CAN_COUNT && cnten_reg[g] == CNTEN_ON) begin
          chk = ERR_CH2CNT;
        end else if (cnten_reg[g] > CNTEN_ON) begin
          chk = ERR_CNTEN;
        end else if (cnten_reg[g] == CNTEN_ON && (preset == '0 || preset > PRESET_MAX)) begin
          chk = ERR_PRESET;
        end
      end

      // Start edge detector; its reset value matches the idle start level.
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          start_d_reg <= 1'b0;
        end else begin
          start_d_reg <= start_in[g];
        end
      end

      // The error word keeps its code until the next start edge.
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          err_reg[g] <= ERR_NONE;
        end else if (start_rise) begin
          err_reg[g] <= chk;
        end
      end

      // Channel two never counts, whatever its enable word holds.
      // counting mode
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          counted_reg <= 1'b0;
        end else if (start_rise) begin
          counted_reg <= CAN_COUNT && (cnten_reg[g] == CNTEN_ON);
        end
      end

      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          duty_scan_reg <= '0;
        end else if (start_rise || scan_tick) begin
          duty_scan_reg <= duty_reg[g][6:0];
        end
      end

      // A start edge hands the fresh duty straight to the channel, which
      // latches it on that same edge; waiting for a scan would let the first
      // period run on a stale duty.
      assign duty_now = start_rise ? duty_reg[g][6:0] : duty_scan_reg;

      // Reach looks one pulse ahead, so the run stops on the period end that
      // completes the last preset pulse.
      assign reach = counted_reg && (pcnt_reg + 32'h00000001 >= preset);
      assign stop_now = pend && reach;

      // A refused start leaves the bit low, so no pulse leaves a channel
      // whose words failed the check.
      // run while start high
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          running_flag[g] <= 1'b0;
        end else if (!start_in[g]) begin
          running_flag[g] <= 1'b0;
        end else if (start_rise) begin
          running_flag[g] <= (chk == ERR_NONE);
        end else if (stop_now) begin
          running_flag[g] <= 1'b0;
        end
      end

      // Pulse counter, cleared on a start edge and stepped at each period end.
      // It holds after a stop, which keeps the overrun test stable.
      always_ff @(posedge mclk) begin
        if (sys_rst || start_rise) begin
          pcnt_reg <= '0;
        end else if (pend) begin
          pcnt_reg <= pcnt_reg + 32'h00000001;
        end
      end

      // The published pair is taken whole at a scan tick, so software reading both
      // words within one scan sees a high word and a low word from the same count.
      // scan publish
      always_ff @(posedge mclk) begin
        if (sys_rst || start_rise) begin
          cntpub_reg[g] <= '0;
        end else if (CAN_COUNT && running_flag[g] && scan_tick) begin
          cntpub_reg[g] <= pend ? pcnt_reg + 32'h00000001 : pcnt_reg;
        end
      end

      // The start edge clears the bit before a new run can set it again.
      // done bit
      always_ff @(posedge mclk) begin
        if (sys_rst || start_rise) begin
          done_flag[g] <= 1'b0;
        end else if (running_flag[g] && (!start_in[g] || stop_now)) begin
          done_flag[g] <= 1'b1;
        end
      end

      // Only a preset lowered during a counted run can leave the count past
      // it, since the run otherwise stops on the preset pulse.
      // overflow bit
      always_ff @(posedge mclk) begin
        if (sys_rst || start_rise) begin
          overrun_flag[g] <= 1'b0;
        end else if (counted_reg && running_flag[g] && pcnt_reg > preset) begin
          overrun_flag[g] <= 1'b1;
        end
      end

      // The period is looked up live; the channel holds it until a wrap.
      assign period_sel = period_of(freq_reg[g]);

      tcp_chan u_chan (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(running_flag[g]),
        .period(period_sel),
        .duty(duty_now),
        .pwm_out(pwm[g]),
        .period_end(pend)
      );

      // Writes to another block, to the status word or to an unmapped
      // address leave this block untouched.
      assign wr_hit = reg_wr && wdec[5] && wdec[4:3] == 2'(g);

      // writable parameter words
      // Only the five parameter words accept writes.
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          freq_reg[g] <= '0;
          duty_reg[g] <= '0;
          cnten_reg[g] <= '0;
          prehi_reg[g] <= '0;
          prelo_reg[g] <= '0;
        end else if (wr_hit) begin
          case (wdec[2:0])
            W_FREQ: freq_reg[g] <= reg_wdata;
            W_DUTY: duty_reg[g] <= reg_wdata;
            W_CNTEN: cnten_reg[g] <= reg_wdata;
            W_PRE_HI: prehi_reg[g] <= reg_wdata;
            W_PRE_LO: prelo_reg[g] <= reg_wdata;
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // Read data stand only in the cycle after the read strobe.
  // The status word packs running, done and overrun bits from the bottom up.
  always_ff @(posedge mclk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == STATUS_OFS) begin
      reg_rdata <= {7'h00, overrun_flag, done_flag, running_flag};
    end else if (rdec[5]) begin
      case (rdec[2:0])
        W_FREQ: reg_rdata <= freq_reg[rdec[4:3]];
        W_DUTY: reg_rdata <= duty_reg[rdec[4:3]];
        W_CNTEN: reg_rdata <= cnten_reg[rdec[4:3]];
        W_PRE_HI: reg_rdata <= prehi_reg[rdec[4:3]];
        W_PRE_LO: reg_rdata <= prelo_reg[rdec[4:3]];
        W_CNT_HI: reg_rdata <= cntpub_reg[rdec[4:3]][31:16];
        W_CNT_LO: reg_rdata <= cntpub_reg[rdec[4:3]][15:0];
        default: reg_rdata <= err_reg[rdec[4:3]];
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : tcp_top
`default_nettype wire

/* rtl/tcp_pkg.sv */
// Constants shared by the three-channel pulse-width unit.
`default_nettype none
package tcp_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MHZ_PER_HZ = 1000;
  // Output frequencies in millihertz, first and second hardware variant.
  localparam int unsigned FREQ_A0_MHZ = 11_440;
  localparam int unsigned FREQ_A1_MHZ = 45_780;
  localparam int unsigned FREQ_A2_MHZ = 366_200;
  localparam int unsigned FREQ_B0_MHZ = 15_260;
  localparam int unsigned FREQ_B1_MHZ = 61_040;
  localparam int unsigned FREQ_B2_MHZ = 488_300;
  // Scan interval that paces count refresh and duty pickup.
  localparam int unsigned SCAN_US = 1000;
  localparam int unsigned US_PER_S = 1_000_000;

  localparam int NUM_CH = 3;
  localparam int WORDS_PER_CH = 8;
  localparam int AW = 5;
  localparam int DW = 16;
  localparam int CW = 32;

  // Word indices inside one channel's parameter block.
  localparam logic [2:0] W_FREQ = 3'h0;
  localparam logic [2:0] W_DUTY = 3'h1;
  localparam logic [2:0] W_CNTEN = 3'h2;
  localparam logic [2:0] W_PRE_HI = 3'h3;
  localparam logic [2:0] W_PRE_LO = 3'h4;
  localparam logic [2:0] W_CNT_HI = 3'h5;
  localparam logic [2:0] W_CNT_LO = 3'h6;
  localparam logic [2:0] W_ERR = 3'h7;
  localparam logic [AW-1:0] STATUS_OFS = 5'h18;

  localparam logic [DW-1:0] FREQ_MAX = 16'h0002;
  localparam logic [DW-1:0] DUTY_MIN = 16'h0001;
  localparam logic [DW-1:0] DUTY_MAX = 16'h0064;
  localparam logic [DW-1:0] CNTEN_ON = 16'h0001;
  localparam logic [CW-1:0] PRESET_MAX = 32'h05F5E100;
  localparam logic [CW-1:0] PERCENT = 32'h00000064;

  localparam logic [DW-1:0] ERR_NONE = 16'h0000;
  localparam logic [DW-1:0] ERR_FREQ = 16'h0001;
  localparam logic [DW-1:0] ERR_DUTY = 16'h0002;
  localparam logic [DW-1:0] ERR_CNTEN = 16'h0003;
  localparam logic [DW-1:0] ERR_PRESET = 16'h0004;
  localparam logic [DW-1:0] ERR_CH2CNT = 16'h0005;

  function automatic int unsigned period_cycles(input int unsigned mhz);
    longint unsigned p;
    p = longint'(CLK_HZ) * longint'(MHZ_PER_HZ) / longint'(mhz);
    return int'(p);
  endfunction : period_cycles
endpackage : tcp_pkg
`default_nettype wire

/* rtl/tcp_chan.sv */
// One pulse-width channel: period counter and compare output.
`default_nettype none
module tcp_chan
  import tcp_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic run, // High while the channel generates.
  input wire logic [CW-1:0] period, // Period in clock cycles.
  input wire logic [6:0] duty, // Duty in percent, 1 to 100.
  output logic pwm_out, // Registered pulse output.
  output logic period_end // One-cycle pulse at each completed period.
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] per_reg;
  logic [6:0] duty_reg;
  logic last;

  assign last = (cnt_reg == per_reg - 32'h00000001);
  assign period_end = run && last;

  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      cnt_reg <= '0;
    end else if (last) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001;
    end
  end

  // boundary latch
  // A new period or duty is taken only while idle or at a wrap, so a change
  // of either never cuts a pulse short or stretches it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      per_reg <= 32'h00000001;
      duty_reg <= '0;
    end else if (!run || last) begin
      per_reg <= period;
      duty_reg <= duty;
    end
  end

  // high time
  // High while cnt*100 is below period*duty.
  // The output shows the count of the cycle before, so the first pulse of a
  // run is whole and no stray pulse follows a counted stop.
  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (cnt_reg * PERCENT) < (per_reg * {25'h0000000, duty_reg});
    end
  end
endmodule : tcp_chan
`default_nettype wire

/* testbench/tcp_ctrl_model.sv */
// Controller-side model that presents the start levels to the unit.
`default_nettype none
module tcp_ctrl_model
  import tcp_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic sys_rst, // Synchronous reset.
  input wire logic [NUM_CH-1:0] start_req, // Start levels asked by the program.
  output var logic [NUM_CH-1:0] start_in // Start levels toward the unit.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial start_in = '0;
  // The program changes its start levels only once per clock, right after the edge.
  always @(posedge mclk) begin
    start_in <= sys_rst ? '0 : start_req;
  end
endmodule : tcp_ctrl_model
`default_nettype wire

/* testbench/tcp_top_sva.sv */
// Checker for the status and output behaviour of the pulse-width unit.
`default_nettype none
module tcp_top_sva
  import tcp_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic [NUM_CH-1:0] start_in, // Start levels.
  input wire logic pulse_out_a, // Channel one output.
  input wire logic [NUM_CH-1:0] pulse_oe, // Output enables.
  input wire logic [NUM_CH-1:0] running_flag, // Running bits.
  input wire logic [NUM_CH-1:0] done_flag, // Done bits.
  input wire logic [NUM_CH-1:0] overrun_flag // Overrun bits.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_oe_follows_run: assert property (pulse_oe == running_flag)
    else $error("output enable differs from running bit");
  a_idle_out_low: assert property (!running_flag[0] && !$past(running_flag[0]) |-> !pulse_out_a)
    else $error("idle channel one drives a pulse");
  a_run_from_start: assert property ((running_flag & ~$past(running_flag) & ~$past(start_in)) == '0)
    else $error("run began without a start");
  a_stop_on_drop: assert property ((running_flag & ~$past(start_in)) == '0)
    else $error("run kept after start fell");
  a_done_on_stop: assert property ($fell(running_flag[0]) |-> ##[0:1] done_flag[0])
    else $error("done bit missing after stop");
  a_done_clears: assert property ($rose(start_in[2]) |=> !done_flag[2])
    else $error("done bit kept after start rise");
  a_run_done_apart: assert property ((running_flag & done_flag) == '0)
    else $error("running and done together");
  a_two_no_over: assert property (!overrun_flag[1])
    else $error("overrun on channel two");
  a_over_clears: assert property ($rose(start_in[0]) |=> !overrun_flag[0])
    else $error("overrun kept after start rise");
  c_run_one: cover property ($rose(running_flag[0]));
  c_done_three: cover property ($rose(done_flag[2]));
  c_over_three: cover property ($rose(overrun_flag[2]));
endmodule : tcp_top_sva
bind tcp_top tcp_top_sva chk_u (.mclk, .sys_rst, .start_in, .pulse_out_a, .pulse_oe,
  .running_flag, .done_flag, .overrun_flag);
`default_nettype wire

/* testbench/tcp_top_test.sv */
// Self-checking bench for the three-channel pulse-width unit.
`default_nettype none
module tcp_top_test
  import tcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P0 = 200;
  localparam int P1 = 100;
  localparam int P2 = 50;
  localparam int PB0 = 160;
  localparam int PB1 = 80;
  localparam int PB2 = 40;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DW-1:0] reg_rdata;
  logic [NUM_CH-1:0] start_req = '0;
  logic [NUM_CH-1:0] start_in, pulse_oe, running_flag, done_flag, overrun_flag;
  logic pulse_out_a, pulse_out_b, pulse_out_c, pb_b, pv;
  logic [3:0] outs;
  int fails = 0;
  int compares = 0;
  int hi, lo, k;
  int per [3] = '{P0, P1, P2};
  int perb [3] = '{PB0, PB1, PB2};
  assign outs = {pb_b, pulse_out_c, pulse_out_b, pulse_out_a};
  always #12.5 mclk = ~mclk;
  tcp_top #(.PERIOD_A0(P0), .PERIOD_A1(P1), .PERIOD_A2(P2), .SCAN_CYCLES(20)) dut_u (
    .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .start_in,
    .pulse_out_a, .pulse_out_b, .pulse_out_c, .pulse_oe, .running_flag, .done_flag,
    .overrun_flag);
  tcp_top #(.VARIANT(1'b1), .PERIOD_B0(PB0), .PERIOD_B1(PB1), .PERIOD_B2(PB2),
            .SCAN_CYCLES(20)) dut_b_u (
    .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(), .start_in,
    .pulse_out_a(), .pulse_out_b(pb_b), .pulse_out_c(), .pulse_oe(), .running_flag(),
    .done_flag(), .overrun_flag());
  tcp_ctrl_model ctl_u (.mclk, .sys_rst, .start_req, .start_in);
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, s, got, exp);
    end
  endtask : chk
  function automatic logic [AW-1:0] ad(input logic [1:0] c, input logic [2:0] w);
    return {c, w};
  endfunction : ad
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e, "read data");
  endtask : rdc
  task automatic cfg(input logic [1:0] c, input logic [DW-1:0] f, d, en, input logic [CW-1:0] p);
    wr(ad(c, W_FREQ), f);
    wr(ad(c, W_DUTY), d);
    wr(ad(c, W_CNTEN), en);
    wr(ad(c, W_PRE_HI), p[31:16]);
    wr(ad(c, W_PRE_LO), p[15:0]);
  endtask : cfg
  task automatic st(input logic [1:0] c, input logic v);
    @(posedge mclk);
    start_req[c] <= v;
    repeat (4) @(posedge mclk);
    #1;
  endtask : st
  task automatic trial(input logic [1:0] c, input logic [DW-1:0] f, d, en,
                       input logic [CW-1:0] p, input logic [DW-1:0] e);
    cfg(c, f, d, en, p);
    st(c, 1'b1);
    rdc(ad(c, W_ERR), e);
    chk(running_flag[c], e == ERR_NONE, "run bit");
    st(c, 1'b0);
  endtask : trial
  // Measures one full high and low phase of a channel output.
  task automatic meas(input int c);
    k = 0;
    while (outs[c] === 1'b1 && k < 1000) begin
      @(posedge mclk);
      #1;
      k++;
    end
    while (outs[c] !== 1'b1 && k < 1000) begin
      @(posedge mclk);
      #1;
      k++;
    end
    hi = 0;
    lo = 0;
    while (outs[c] === 1'b1 && hi < 1000) begin
      @(posedge mclk);
      #1;
      hi++;
    end
    while (outs[c] !== 1'b1 && lo < 1000) begin
      @(posedge mclk);
      #1;
      lo++;
    end
  endtask : meas
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    trial(0, 16'h0003, 16'h0032, 16'h0000, 32'h0, ERR_FREQ);
    wr(ad(0, W_ERR), 16'h0000);
    rdc(ad(0, W_ERR), ERR_FREQ);
    wr(ad(0, W_CNT_LO), 16'hFFFF);
    rdc(ad(0, W_CNT_LO), 16'h0000);
    rdc(5'h1F, 16'h0000);
    trial(0, 16'h0002, 16'h0000, 16'h0000, 32'h0, ERR_DUTY);
    trial(0, 16'h0002, 16'h0065, 16'h0000, 32'h0, ERR_DUTY);
    trial(0, 16'h0002, 16'h0064, 16'h0002, 32'h0, ERR_CNTEN);
    trial(2, 16'h0002, 16'h0032, 16'h0001, 32'h0, ERR_PRESET);
    trial(2, 16'h0002, 16'h0032, 16'h0001, PRESET_MAX + 1, ERR_PRESET);
    trial(1, 16'h0002, 16'h0032, 16'h0001, 32'h0, ERR_CH2CNT);
    trial(2, 16'h0002, 16'h0001, 16'h0001, PRESET_MAX, ERR_NONE);
    rdc(ad(2, W_PRE_HI), PRESET_MAX[31:16]);
    $display("test error codes done");
    for (int f = 0; f < 3; f++) begin
      trial(1, f[15:0], 16'h0019, 16'h0000, 32'h0, ERR_NONE);
      st(1, 1'b1);
      meas(1);
      chk(hi + lo, per[f], "period");
      chk(hi, (per[f] * 25 + 99) / 100, "high time");
      meas(3);
      chk(hi + lo, perb[f], "second variant period");
      st(1, 1'b0);
    end
    $display("test frequency codes done");
    cfg(1, 16'h0001, 16'h0019, 16'h0000, 32'h0);
    st(1, 1'b1);
    wr(ad(1, W_DUTY), 16'h004B);
    repeat (300) @(posedge mclk);
    meas(1);
    chk(hi, 75, "new duty high");
    chk(lo, 25, "new duty low");
    st(1, 1'b0);
    chk(running_flag[1], 1'b0, "stopped");
    chk(done_flag[1], 1'b1, "done after drop");
    $display("test duty change done");
    cfg(0, 16'h0002, 16'h0032, 16'h0001, 32'h3);
    @(posedge mclk);
    start_req[0] <= 1'b1;
    k = 0;
    pv = 1'b0;
    repeat (400) begin
      @(posedge mclk);
      #1;
      if (pulse_out_a === 1'b1 && pv === 1'b0) begin
        k++;
      end
      pv = pulse_out_a;
    end
    chk(k, 3, "counted pulses");
    chk(running_flag[0], 1'b0, "counted stop");
    rdc(STATUS_OFS, 16'h0038);
    st(0, 1'b0);
    $display("test counted run done");
    cfg(2, 16'h0002, 16'h0032, 16'h0001, 32'h28);
    st(2, 1'b1);
    meas(2);
    chk(hi, 25, "channel three high");
    repeat (200) @(posedge mclk);
    rdc(ad(2, W_CNT_HI), 16'h0000);
    @(posedge mclk);
    reg_addr <= ad(2, W_CNT_LO);
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata >= 4 && reg_rdata <= 7, 1'b1, "live count");
    wr(ad(2, W_PRE_LO), 16'h0002);
    repeat (120) @(posedge mclk);
    #1;
    chk(overrun_flag[2], 1'b1, "overrun set");
    st(2, 1'b0);
    chk(done_flag[2], 1'b1, "done set");
    st(2, 1'b1);
    chk(overrun_flag[2], 1'b0, "overrun cleared");
    st(2, 1'b0);
    $display("test overrun done");
    end_of_test();
  end
endmodule : tcp_top_test
`default_nettype wire
